// ---- shared/fault_irq_pkg.sv ----
// Constants for the fault and interrupt status register bank
// ----------------------------------------------------------------------------
// Contract
// - Source 1 bit 7 latches bus stuck dominant
// - Source 1 bit 6 latches TXD/RXD short
// - Source 1 bit 4 TXD dominant; bit 5 zero
// - Source 1 bits 3/2 latch CANL shorts
// - Source 1 bits 1/0 latch CANH shorts
// - Source 2 bit 3 latches thermal recovery
// - Source 2 bit 2 latches thermal warning
// - Source 2 bits 1/0 latch local/remote wake
// - Source 3 bits 7/6 regulator C events
// - Source 3 bits 5/4 regulator B events
// - Source 3 bits 3/2 buck output events
// - Source 3 bits 1/0 battery supply events
// - Bus status shows live faults, bit 5 zero
// - Thermal status bit 1 live recovery flag
// - Thermal status bit 0 live warning flag
// - Summary register flags pending source groups
// ----------------------------------------------------------------------------
package fault_irq_pkg;
   // Register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [7:0] SUMMARY_OFS = 8'h07;
   localparam logic [7:0] BUS_SRC_OFS = 8'h08;
   localparam logic [7:0] WAKE_SRC_OFS = 8'h09;
   localparam logic [7:0] SUPPLY_SRC_OFS = 8'h0A;
   localparam logic [7:0] RESERVED_OFS = 8'h0B;
   localparam logic [7:0] BUS_STAT_OFS = 8'h0C;
   localparam logic [7:0] THERM_STAT_OFS = 8'h0D;
   localparam logic [7:0] SUPPLY_STAT_OFS = 8'h0E;
   // Implemented bits of each register, reserved bits read zero
   localparam logic [7:0] BUS_MASK = 8'hDF;
   localparam logic [7:0] WAKE_MASK = 8'h0F;
   localparam logic [7:0] SUPPLY_MASK = 8'hFF;
   // Reset values
   localparam logic [7:0] SRC_RESET = 8'h00;
   localparam logic [7:0] SUPPLY_STAT_RESET = 8'hAA;
   // Detector vector layout: {supply[7:0], wake_thermal[3:0], bus[7:0]}
   localparam int DET_W = 20;
   localparam int BUS_LSB = 0;
   localparam int WAKE_LSB = 8;
   localparam int SUPPLY_LSB = 12;
   localparam logic [19:0] DET_RESET = 20'hAA000;
   // Bit positions inside the source registers
   localparam int BUS_STUCK_BIT = 7;
   localparam int TXRX_SHORT_BIT = 6;
   localparam int TXD_DOM_BIT = 4;
   localparam int CANL_VCC_BIT = 3;
   localparam int CANL_GND_BIT = 2;
   localparam int CANH_GND_BIT = 1;
   localparam int CANH_VCC_BIT = 0;
   localparam int RECOVERY_BIT = 3;
   localparam int WARNING_BIT = 2;
   localparam int LOCAL_WAKE_BIT = 1;
   localparam int REMOTE_WAKE_BIT = 0;
   // Bit positions inside the summary and thermal status registers
   localparam int SUM_BUS_BIT = 0;
   localparam int SUM_WAKE_BIT = 1;
   localparam int SUM_SUPPLY_BIT = 2;
   localparam int STAT_RECOVERY_BIT = 1;
   localparam int STAT_WARNING_BIT = 0;
endpackage

// ---- design/fault_interrupt_status_bank.sv ----
// Latched interrupt sources, live status and interrupt output of the device
`timescale 1ns/10ps
module fault_interrupt_status_bank #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic clk,
   input wire logic srst,
   // Register port from the serial interface
   input wire logic [fault_irq_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [fault_irq_pkg::DATA_W-1:0] reg_wdata,
   output logic [fault_irq_pkg::DATA_W-1:0] reg_rdata,
   // Bus and pin fault detectors
   input wire logic bus_stuck_dominant,
   input wire logic txd_rxd_short,
   input wire logic txd_dominant_timeout,
   input wire logic canl_short_supply,
   input wire logic canl_short_ground,
   input wire logic canh_short_ground,
   input wire logic canh_short_supply,
   // Thermal and wake detectors
   input wire logic thermal_recovery_flag,
   input wire logic thermal_warning_flag,
   input wire logic local_wake,
   input wire logic remote_wake,
   // Supply monitors
   input wire logic regulator_c_power_good,
   input wire logic regulator_c_undervoltage,
   input wire logic regulator_b_power_good,
   input wire logic regulator_b_undervoltage,
   input wire logic buck_output_power_good,
   input wire logic buck_output_undervoltage,
   input wire logic battery_power_good,
   input wire logic battery_undervoltage,
   // Interrupt toward the controller
   output logic interrupt_out_n
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
   end

   // The detector packing below assumes exactly this package layout
   if (fault_irq_pkg::BUS_LSB != 0) begin : g_bad_bus_lsb
      $error("Bus group must start the detector vector");
   end
   if (fault_irq_pkg::WAKE_LSB != fault_irq_pkg::BUS_LSB + 8) begin : g_bad_wake_lsb
      $error("Wake and thermal group must follow the bus group");
   end
   if (fault_irq_pkg::SUPPLY_LSB != fault_irq_pkg::WAKE_LSB + 4) begin : g_bad_supply_lsb
      $error("Supply group must follow the wake and thermal group");
   end
   if (fault_irq_pkg::DET_W != fault_irq_pkg::SUPPLY_LSB + 8) begin : g_bad_det_w
      $error("Detector vector width must cover all three groups");
   end
   if (fault_irq_pkg::ADDR_W != 8 || fault_irq_pkg::DATA_W != 8) begin : g_bad_port_w
      $error("Register port must be eight bits wide");
   end
   if (fault_irq_pkg::BUS_MASK[5] || fault_irq_pkg::WAKE_MASK[7:4] != 4'h0) begin : g_bad_mask
      $error("Reserved source bits must stay masked");
   end

   // ----------------------------------------------------------------------
   // Detector collection
   // ----------------------------------------------------------------------
   localparam int W = fault_irq_pkg::DET_W;
   logic [W-1:0] det_raw;
   logic [7:0] bus_raw;
   logic [3:0] wake_raw;
   logic [7:0] supply_raw;

   // Place each detector at its source register bit position
   always_comb begin
      bus_raw = 8'h00;
      bus_raw[fault_irq_pkg::BUS_STUCK_BIT] = bus_stuck_dominant;
      bus_raw[fault_irq_pkg::TXRX_SHORT_BIT] = txd_rxd_short;
      bus_raw[fault_irq_pkg::TXD_DOM_BIT] = txd_dominant_timeout;
      bus_raw[fault_irq_pkg::CANL_VCC_BIT] = canl_short_supply;
      bus_raw[fault_irq_pkg::CANL_GND_BIT] = canl_short_ground;
      bus_raw[fault_irq_pkg::CANH_GND_BIT] = canh_short_ground;
      bus_raw[fault_irq_pkg::CANH_VCC_BIT] = canh_short_supply;
      wake_raw = 4'h0;
      wake_raw[fault_irq_pkg::RECOVERY_BIT] = thermal_recovery_flag;
      wake_raw[fault_irq_pkg::WARNING_BIT] = thermal_warning_flag;
      wake_raw[fault_irq_pkg::LOCAL_WAKE_BIT] = local_wake;
      wake_raw[fault_irq_pkg::REMOTE_WAKE_BIT] = remote_wake;
      supply_raw = {regulator_c_power_good,
                    regulator_c_undervoltage,
                    regulator_b_power_good,
                    regulator_b_undervoltage,
                    buck_output_power_good,
                    buck_output_undervoltage,
                    battery_power_good,
                    battery_undervoltage};
      det_raw = {supply_raw, wake_raw, bus_raw};
   end

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   logic [W-1:0] sync_q [SYNC_STAGES];
   logic [W-1:0] sync_d [SYNC_STAGES];
   logic [W-1:0] prev_q;
   logic [W-1:0] prev_d;
   logic [W-1:0] live;
   logic [W-1:0] rise;

   // Shift chain; only the last stage is looked at by logic
   always_comb begin
      sync_d[0] = det_raw;
      for (int i = 1; i < SYNC_STAGES; i++) begin
         sync_d[i] = sync_q[i-1];
      end
      prev_d = sync_q[SYNC_STAGES-1];
   end

   // Supplies start out good so reset itself raises no event
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            sync_q[i] <= fault_irq_pkg::DET_RESET;
         end
         prev_q <= fault_irq_pkg::DET_RESET;
      end else begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            sync_q[i] <= sync_d[i];
         end
         prev_q <= prev_d;
      end
   end

   // A detector event is the moment its flag sets
   assign live = sync_q[SYNC_STAGES-1];
   assign rise = live & ~prev_q;

   // ----------------------------------------------------------------------
   // Latched interrupt sources
   // ----------------------------------------------------------------------
   logic [7:0] bus_src_q;
   logic [7:0] bus_src_d;
   logic [7:0] wake_src_q;
   logic [7:0] wake_src_d;
   logic [7:0] supply_src_q;
   logic [7:0] supply_src_d;
   logic [7:0] bus_set;
   logic [7:0] wake_set;
   logic [7:0] supply_set;
   logic wr_bus;
   logic wr_wake;
   logic wr_supply;

   // Write back zero clears a bit; a fresh event in that cycle wins
   function automatic logic [7:0] next_source(
      input logic [7:0] cur,
      input logic [7:0] set,
      input logic wr,
      input logic [7:0] wdata,
      input logic [7:0] mask
   );
      logic [7:0] kept;
      kept = wr ? (cur & wdata) : cur;
      return (kept | set) & mask;
   endfunction

   // Address match used for write strobes and the read mux
   function automatic logic hit(
      input logic [fault_irq_pkg::ADDR_W-1:0] addr,
      input logic [7:0] ofs
   );
      return addr == ofs;
   endfunction

   // Event vectors per source register
   always_comb begin
      bus_set = rise[fault_irq_pkg::BUS_LSB +: 8];
      wake_set = {4'h0, rise[fault_irq_pkg::WAKE_LSB +: 4]};
      supply_set = rise[fault_irq_pkg::SUPPLY_LSB +: 8];
   end

   // Write strobes per source register
   always_comb begin
      wr_bus = reg_wr && hit(reg_addr, fault_irq_pkg::BUS_SRC_OFS);
      wr_wake = reg_wr && hit(reg_addr, fault_irq_pkg::WAKE_SRC_OFS);
      wr_supply = reg_wr && hit(reg_addr, fault_irq_pkg::SUPPLY_SRC_OFS);
   end

   // Next source values; bits hold until cleared by a zero write
   always_comb begin
      bus_src_d = next_source(bus_src_q, bus_set, wr_bus, reg_wdata,
                              fault_irq_pkg::BUS_MASK);
      wake_src_d = next_source(wake_src_q, wake_set, wr_wake, reg_wdata,
                               fault_irq_pkg::WAKE_MASK);
      supply_src_d = next_source(supply_src_q, supply_set, wr_supply, reg_wdata,
                                 fault_irq_pkg::SUPPLY_MASK);
   end

   // Source registers
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_src_q <= fault_irq_pkg::SRC_RESET;
         wake_src_q <= fault_irq_pkg::SRC_RESET;
         supply_src_q <= fault_irq_pkg::SRC_RESET;
      end else begin
         bus_src_q <= bus_src_d;
         wake_src_q <= wake_src_d;
         supply_src_q <= supply_src_d;
      end
   end

   // ----------------------------------------------------------------------
   // Live status and summary views
   // ----------------------------------------------------------------------
   logic [7:0] bus_stat;
   logic [7:0] therm_stat;
   logic [7:0] supply_stat;
   logic [7:0] summary;

   // Status follows the synchronised detectors directly
   always_comb begin
      bus_stat = live[fault_irq_pkg::BUS_LSB +: 8]
                 & fault_irq_pkg::BUS_MASK;
      therm_stat = 8'h00;
      therm_stat[fault_irq_pkg::STAT_RECOVERY_BIT] =
         live[fault_irq_pkg::WAKE_LSB + fault_irq_pkg::RECOVERY_BIT];
      therm_stat[fault_irq_pkg::STAT_WARNING_BIT] =
         live[fault_irq_pkg::WAKE_LSB + fault_irq_pkg::WARNING_BIT];
      supply_stat = live[fault_irq_pkg::SUPPLY_LSB +: 8];
   end

   // One summary bit per source register
   always_comb begin
      summary = 8'h00;
      summary[fault_irq_pkg::SUM_BUS_BIT] = |bus_src_q;
      summary[fault_irq_pkg::SUM_WAKE_BIT] = |wake_src_q;
      summary[fault_irq_pkg::SUM_SUPPLY_BIT] = |supply_src_q;
   end

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   // Read mux; unmapped and reserved offsets return zero
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd) begin
         if (hit(reg_addr, fault_irq_pkg::SUMMARY_OFS)) begin
            rdata_d = summary;
         end else if (hit(reg_addr, fault_irq_pkg::BUS_SRC_OFS)) begin
            rdata_d = bus_src_q;
         end else if (hit(reg_addr, fault_irq_pkg::WAKE_SRC_OFS)) begin
            rdata_d = wake_src_q;
         end else if (hit(reg_addr, fault_irq_pkg::SUPPLY_SRC_OFS)) begin
            rdata_d = supply_src_q;
         end else if (hit(reg_addr, fault_irq_pkg::BUS_STAT_OFS)) begin
            rdata_d = bus_stat;
         end else if (hit(reg_addr, fault_irq_pkg::THERM_STAT_OFS)) begin
            rdata_d = therm_stat;
         end else if (hit(reg_addr, fault_irq_pkg::SUPPLY_STAT_OFS)) begin
            rdata_d = supply_stat;
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   // Read data register holds until the next read
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ----------------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------------
   logic irq_n_q;
   logic irq_n_d;

   // Low while any latched source bit is set, from the next values
   always_comb begin
      irq_n_d = ~(|bus_src_d | |wake_src_d | |supply_src_d);
   end

   // Registered so the pin never glitches
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= irq_n_d;
      end
   end

   assign interrupt_out_n = irq_n_q;

endmodule

// ---- tb/host_model.sv ----
// Host controller model driving the register port of the bank
`timescale 1ns/10ps
module host_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // Idle port values
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // One-cycle write strobe; released lines show the inverse value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // One-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule

// ---- tb/fault_interrupt_status_bank_properties.sv ----
// Concurrent checks on the register port and the interrupt output
`timescale 1ns/10ps
module fault_bank_checker #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic bus_stuck_dominant,
   input wire logic local_wake,
   input wire logic interrupt_out_n
);
   localparam int LAT = SYNC_STAGES + 1;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Read request of one offset, and the latched output afterwards
   sequence s_rd(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence
   sequence s_set;
      ##LAT !interrupt_out_n;
   endsequence
   chk_bus_rsvd: assert property (s_rd(8'h0C) |=> !reg_rdata[5])
      else $error("bus status bit 5 set");
   chk_wake_rsvd: assert property (s_rd(8'h09) |=> reg_rdata[7:4] == 4'h0)
      else $error("wake source reserved bits set");
   chk_therm_rsvd: assert property (s_rd(8'h0D) |=> reg_rdata[7:2] == 6'h00)
      else $error("thermal status reserved bits set");
   chk_summary_irq: assert property (s_rd(8'h07) |=> {reg_rdata[7:3] == 5'h00,
      reg_rdata[2:0] != 3'h0} == {1'b1, !$past(interrupt_out_n)}) else $error("summary disagrees with output");
   chk_src_irq: assert property (s_rd(8'h08) |=> reg_rdata == 8'h00 || !$past(interrupt_out_n))
      else $error("source set but output high");
   chk_irq_release: assert property ($rose(interrupt_out_n) |-> $past(reg_wr) || $past(srst))
      else $error("output released without a write");
   chk_fault_latency: assert property ($rose(bus_stuck_dominant) |-> s_set)
      else $error("stuck fault not latched in time");
   chk_wake_latency: assert property ($rose(local_wake) |-> s_set)
      else $error("local wake not latched in time");
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule
bind fault_interrupt_status_bank fault_bank_checker #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.clk, .srst, .reg_addr,
   .reg_wr, .reg_rd, .reg_rdata, .bus_stuck_dominant, .local_wake, .interrupt_out_n);

// ---- tb/test_fault_interrupt_status_bank.sv ----
// Self-checking bench for the interrupt source and status bank
`timescale 1ns/10ps
module test_fault_interrupt_status_bank;
   logic clk, srst, reg_wr, reg_rd, interrupt_out_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
   logic [19:0] det;
   logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAA};
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   host_model u_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   fault_interrupt_status_bank #(.SYNC_STAGES(2)) u_fault_interrupt_status_bank (.clk(clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .bus_stuck_dominant(det[7]), .txd_rxd_short(det[6]), .txd_dominant_timeout(det[4]),
      .canl_short_supply(det[3]), .canl_short_ground(det[2]), .canh_short_ground(det[1]),
      .canh_short_supply(det[0]), .thermal_recovery_flag(det[11]), .thermal_warning_flag(det[10]),
      .local_wake(det[9]), .remote_wake(det[8]), .regulator_c_power_good(det[19]),
      .regulator_c_undervoltage(det[18]), .regulator_b_power_good(det[17]), .regulator_b_undervoltage(det[16]),
      .buck_output_power_good(det[15]), .buck_output_undervoltage(det[14]), .battery_power_good(det[13]),
      .battery_undervoltage(det[12]), .interrupt_out_n(interrupt_out_n));

   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic final_report;
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      u_host_model.rd(a, got);
      check(got, e);
   endtask

   // Live status expected from the detector levels
   function automatic logic [7:0] stat(input logic [7:0] a);
      case (a)
         8'h0C: stat = det[7:0] & 8'hDF;
         8'h0D: stat = {6'h00, det[11:10]};
         default: stat = det[19:12];
      endcase
   endfunction

   // Whole map at reset values, plus an unmapped offset
   task automatic idle_all;
      for (int i = 0; i < 8; i++) rc(8'(7 + i), rst_tab[i]);
      rc(8'h3F, 8'h00);
   endtask

   // One detector: event, live status, sticky source, clear
   task automatic ev(input int b);
      int r;
      logic [7:0] m;
      r = b < 8 ? 0 : (b < 12 ? 1 : 2);
      m = 8'h01 << (b - (r == 0 ? 0 : 4 * r + 4));
      det[b] = 1'b0;
      repeat (4) @(negedge clk);
      det[b] = 1'b1;
      repeat (4) @(negedge clk);
      for (int s = 12; s < 15; s++) rc(8'(s), stat(8'(s)));
      det[b] = fault_irq_pkg::DET_RESET[b];
      repeat (4) @(negedge clk);
      rc(8'(8 + r), m);
      rc(8'h07, 8'(1 << r));
      check({7'h00, interrupt_out_n}, 8'h00);
      u_host_model.wr(8'(8 + r), ~m);
      rc(8'(8 + r), 8'h00);
      check({7'h00, interrupt_out_n}, 8'h01);
   endtask

   initial begin
      srst = 1'b1;
      det = fault_irq_pkg::DET_RESET;
      repeat (12) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      idle_all();
      // Writes of ones set nothing and leave read-only places alone
      for (int i = 7; i < 15; i++) u_host_model.wr(8'(i), 8'hFF);
      u_host_model.wr(8'h3F, 8'hFF);
      idle_all();
      for (int b = 0; b < 20; b++) if (b != 5) ev(b);
      // Two groups pending; a held level gives one event only
      det[0] = 1'b1;
      det[12] = 1'b1;
      repeat (4) @(negedge clk);
      rc(8'h07, 8'h05);
      // A clear that meets a fresh event in the same cycle leaves that bit set
      det[3] = 1'b1;
      @(negedge clk);
      u_host_model.wr(8'h08, 8'h00);
      rc(8'h08, 8'h08);
      u_host_model.wr(8'h08, 8'h00);
      rc(8'h08, 8'h00);
      check({7'h00, interrupt_out_n}, 8'h00);
      u_host_model.wr(8'h0A, 8'hFE);
      rc(8'h0A, 8'h00);
      check({7'h00, interrupt_out_n}, 8'h01);
      // Reset in mid-run clears a pending source
      det = fault_irq_pkg::DET_RESET;
      det[7] = 1'b1;
      repeat (6) @(negedge clk);
      check({7'h00, interrupt_out_n}, 8'h00);
      det = fault_irq_pkg::DET_RESET;
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      idle_all();
      check({7'h00, interrupt_out_n}, 8'h01);
      final_report();
   end
endmodule
